// ### pkg/tcev_pkg.sv
/*
 * Shared constants for the timer event-action and interrupt-enable block:
 * register offsets, field positions, reset values and action codes.
 * Assumes an 8-bit byte address and 32-bit register data.
 */
package tcev_pkg;

   localparam int TCEV_AW = 8;
   localparam int TCEV_DW = 32;

   ////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] TCEV_OFS_EVENT_CTRL = 8'h20;
   localparam logic [7:0] TCEV_OFS_ENABLE_CLR = 8'h24;
   localparam logic [7:0] TCEV_OFS_ENABLE_SET = 8'h28;
   localparam logic [7:0] TCEV_OFS_TRIP_STAT = 8'h3c;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [31:0] TCEV_RST_ENABLE = 32'h0000_0000;
   localparam logic [5:0] TCEV_RST_EVENT_CTRL = 6'h00;
   localparam logic [1:0] TCEV_RST_TRIP = 2'h0;

   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int TCEV_SEL0_LSB = 0;
   localparam int TCEV_SEL1_LSB = 3;
   localparam int TCEV_SEL_W = 3;
   localparam int TCEV_BIT_WRAP = 0;
   localparam int TCEV_BIT_RESTART = 1;
   localparam int TCEV_BIT_CYCLE = 2;
   localparam int TCEV_BIT_OVERRUN = 3;
   localparam int TCEV_BIT_HALT_TRIP = 11;
   localparam int TCEV_BIT_RECOV_A = 12;
   localparam int TCEV_BIT_RECOV_B = 13;
   localparam int TCEV_BIT_NONREC_LO = 14;
   localparam int TCEV_BIT_MATCH_LO = 16;
   localparam logic [31:0] TCEV_ENABLE_IMPL = 32'h000f_f80f;

   ////////////////////////////////////////////////////////////////////////
   // Action codes
   localparam logic [2:0] TCEV_ACT_OFF = 3'h0;
   localparam logic [2:0] TCEV_ACT_RETRIGGER = 3'h1;
   localparam logic [2:0] TCEV_ACT0_TALLY = 3'h2;
   localparam logic [2:0] TCEV_ACT0_START = 3'h3;
   localparam logic [2:0] TCEV_ACT0_STEP_UP = 3'h4;
   localparam logic [2:0] TCEV_ACT0_LEVEL_COUNT = 3'h5;
   localparam logic [2:0] TCEV_ACT0_RESERVED = 3'h6;
   localparam logic [2:0] TCEV_ACT1_DIRECTION = 3'h2;
   localparam logic [2:0] TCEV_ACT1_STOP = 3'h3;
   localparam logic [2:0] TCEV_ACT1_STEP_DOWN = 3'h4;
   localparam logic [2:0] TCEV_ACT1_PERIOD_WIDTH = 3'h5;
   localparam logic [2:0] TCEV_ACT1_WIDTH_PERIOD = 3'h6;
   localparam logic [2:0] TCEV_ACT_FAULT = 3'h7;

endpackage : tcev_pkg

// ### pkg/tcev_act_if.sv
/*
 * Decoded counter actions passed from the event decoder to the top.
 * Assumes one clock domain; every signal is driven from a flip-flop.
 */
`timescale 1ns/100ps
interface tcev_act_if;
   logic start;
   logic retrigger;
   logic tally;
   logic step_up;
   logic level_count;
   logic dir_down;
   logic stop;
   logic step_down;
   logic cap_period_width;
   logic cap_width_period;
   logic fault0;
   logic fault1;

   modport drv (
      output start, retrigger, tally, step_up, level_count, dir_down,
      output stop, step_down, cap_period_width, cap_width_period,
      output fault0, fault1
   );
   modport use_side (
      input start, retrigger, tally, step_up, level_count, dir_down,
      input stop, step_down, cap_period_width, cap_width_period,
      input fault0, fault1
   );
endinterface : tcev_act_if

// ### verilog/tcev_decode.sv
/*
 * Event action decoder: turns the two action selectors and the two
 * event inputs into registered counter commands.
 * Assumes events are synchronous to sys_clk and one cycle per event.
 */
`timescale 1ns/100ps
module tcev_decode (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [2:0] input0_action_sel,
   input wire logic [2:0] input1_action_sel,
   input wire logic timer_event_in0,
   input wire logic timer_event_in1,
   input wire logic counter_running,
   tcev_act_if.drv act
);
   import tcev_pkg::*;

   logic ev0_retrig;
   logic ev1_retrig;

   assign ev0_retrig = timer_event_in0 &&
                       input0_action_sel == TCEV_ACT_RETRIGGER; // R02
   assign ev1_retrig = timer_event_in1 &&
                       input1_action_sel == TCEV_ACT_RETRIGGER; // R23

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         act.start <= 1'b0;
         act.retrigger <= 1'b0;
      end else begin
         // Stopped counter starts; a running one restarts
         act.start <= (ev0_retrig || ev1_retrig) && !counter_running ||
                      timer_event_in0 &&
                      input0_action_sel == TCEV_ACT0_START; // R01 R02 R23
         act.retrigger <= (ev0_retrig || ev1_retrig) &&
                          counter_running; // R02 R23
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         act.tally <= 1'b0;
         act.step_up <= 1'b0;
         act.level_count <= 1'b0;
         act.fault0 <= 1'b0;
      end else begin
         act.tally <= timer_event_in0 &&
                      input0_action_sel == TCEV_ACT0_TALLY; // R01
         act.step_up <= timer_event_in0 &&
                        input0_action_sel == TCEV_ACT0_STEP_UP; // R04
         // Level, not pulse: counts while the input stays active
         act.level_count <= timer_event_in0 &&
                            input0_action_sel == TCEV_ACT0_LEVEL_COUNT; // R03
         act.fault0 <= timer_event_in0 &&
                       input0_action_sel == TCEV_ACT_FAULT; // R01
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         act.dir_down <= 1'b0;
         act.stop <= 1'b0;
         act.step_down <= 1'b0;
         act.cap_period_width <= 1'b0;
         act.cap_width_period <= 1'b0;
         act.fault1 <= 1'b0;
      end else begin
         act.dir_down <= timer_event_in1 &&
                         input1_action_sel == TCEV_ACT1_DIRECTION; // R05
         act.stop <= timer_event_in1 &&
                     input1_action_sel == TCEV_ACT1_STOP; // R05
         act.step_down <= timer_event_in1 &&
                          input1_action_sel == TCEV_ACT1_STEP_DOWN; // R05
         act.cap_period_width <= timer_event_in1 &&
            input1_action_sel == TCEV_ACT1_PERIOD_WIDTH; // R06
         act.cap_width_period <= timer_event_in1 &&
            input1_action_sel == TCEV_ACT1_WIDTH_PERIOD; // R07
         act.fault1 <= timer_event_in1 &&
                       input1_action_sel == TCEV_ACT_FAULT; // R05
      end
   end

endmodule : tcev_decode

// ### verilog/tcev_top.sv
/*
 * Timer event-action selection and paired interrupt-enable registers.
 * Holds the action selectors, the shared enable mask with its clear and
 * set views, a sticky trip status and the masked interrupt request.
 * Assumes a simple register port (read data one cycle after the read
 * strobe), events synchronous to sys_clk, and interrupt flags kept by
 * the counter core outside this block.
 */
// The address-and-strobe port was chosen for this implementation.
// Functional notes
// R01: Input 0 selector: 0 ignores, 2 counts, 3 starts, 6 reserved, 7 faults.
// R02: Input 0 code 1 starts a stopped counter or retriggers a running one.
// R03: Input 0 code 5 counts while the event input stays active.
// R04: Input 0 code 4 increments the counter once per event.
// R05: Input 1: 2 direction level, 3 stop, 4 decrement, 7 fault.
// R06: Input 1 code 5 captures period to register 0, width to 1.
// R07: Input 1 code 6 captures period to register 1, width to 0.
// R08: Clear and set registers share one mask; clear changes show on set.
// R09: Set changes likewise show when the clear register is read.
// R10: Writing zero to an enable bit leaves that enable unchanged.
// R11: Clear bits 19 to 16 disable the channel match interrupts.
// R12: Clear bits 15 and 14 disable the non-recoverable trip interrupts.
// R13: Clear bit 13 disables the recoverable B interrupt.
// R14: Clear bit 12 disables the recoverable A interrupt.
// R15: Clear bit 11 disables the debug-halt trip interrupt.
// R16: Clear bit 3 disables the capture overrun interrupt.
// R17: Clear bit 2 disables the cycle interrupt.
// R18: Clear bit 1 disables the restart interrupt.
// R19: Clear bit 0 disables the wrap interrupt.
// R20: An enable bit reads one when enabled, zero when disabled.
// R21: The set register sits at offset 0x28, no read-modify-write needed.
// R22: Set register ones enable interrupts at the same bit positions.
// R23: Input 1 selector: 0 ignores, 1 starts, restarts or retriggers.
// R24: Interrupt request is high while any enabled flag is set.
// R25: Unimplemented enable bits read zero and ignore writes.
`timescale 1ns/100ps
module tcev_top (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [tcev_pkg::TCEV_AW-1:0] reg_addr,
   input wire logic [tcev_pkg::TCEV_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [tcev_pkg::TCEV_DW-1:0] reg_rdata,
   input wire logic timer_event_in0,
   input wire logic timer_event_in1,
   input wire logic counter_running,
   input wire logic [tcev_pkg::TCEV_DW-1:0] irq_flags,
   output logic [tcev_pkg::TCEV_DW-1:0] irq_enable,
   output logic timer_irq,
   output logic ctr_start,
   output logic ctr_retrigger,
   output logic ctr_tally,
   output logic ctr_step_up,
   output logic ctr_level_count,
   output logic ctr_dir_down,
   output logic ctr_stop,
   output logic ctr_step_down,
   output logic capture_period_width,
   output logic capture_width_period,
   output logic fault_trip0,
   output logic fault_trip1
);
   import tcev_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Address decode

   logic hit_event_ctrl;
   logic hit_enable_clr;
   logic hit_enable_set;
   logic hit_trip_stat;

   assign hit_event_ctrl = reg_addr == TCEV_OFS_EVENT_CTRL;
   assign hit_enable_clr = reg_addr == TCEV_OFS_ENABLE_CLR;
   assign hit_enable_set = reg_addr == TCEV_OFS_ENABLE_SET; // R21
   assign hit_trip_stat = reg_addr == TCEV_OFS_TRIP_STAT;

   logic wr_event_ctrl;
   logic wr_enable_clr;
   logic wr_enable_set;
   logic wr_trip_stat;

   assign wr_event_ctrl = reg_wr && hit_event_ctrl;
   assign wr_enable_clr = reg_wr && hit_enable_clr;
   assign wr_enable_set = reg_wr && hit_enable_set;
   assign wr_trip_stat = reg_wr && hit_trip_stat;

   ////////////////////////////////////////////////////////////////////////
   // Action selectors

   logic [2:0] input0_action_sel_q;
   logic [2:0] input1_action_sel_q;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         input0_action_sel_q <= TCEV_RST_EVENT_CTRL[2:0];
         input1_action_sel_q <= TCEV_RST_EVENT_CTRL[5:3];
      end else if (wr_event_ctrl) begin
         input0_action_sel_q <=
            reg_wdata[TCEV_SEL0_LSB +: TCEV_SEL_W]; // R01
         input1_action_sel_q <=
            reg_wdata[TCEV_SEL1_LSB +: TCEV_SEL_W]; // R23
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Shared enable mask
   // One flop per bit serves both views, so neither view can go stale.

   logic [TCEV_DW-1:0] enable_q;
   logic [TCEV_DW-1:0] enable_d;
   logic [TCEV_DW-1:0] wdata_impl;

   assign wdata_impl = reg_wdata & TCEV_ENABLE_IMPL; // R25

   for (genvar b = 0; b < TCEV_DW; b++) begin : g_enable
      always_comb begin
         enable_d[b] = enable_q[b]; // R10
         if (!TCEV_ENABLE_IMPL[b]) begin
            enable_d[b] = 1'b0; // R25
         end else if (wr_enable_clr && wdata_impl[b]) begin
            enable_d[b] = 1'b0; // R08 R11 R12 R13 R14 R15 R16 R17 R18 R19
         end else if (wr_enable_set && wdata_impl[b]) begin
            enable_d[b] = 1'b1; // R09 R22
         end
         // A zero written anywhere keeps the bit as it was
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         enable_q <= TCEV_RST_ENABLE;
      end else begin
         enable_q <= enable_d;
      end
   end

   assign irq_enable = enable_q;

   ////////////////////////////////////////////////////////////////////////
   // Named views of the mask for the interrupt request gating

   logic [3:0] channel_match_irq_en;
   logic [1:0] nonrecov_trip_irq_en;
   logic recoverable_b_irq_en;
   logic recoverable_a_irq_en;
   logic halted_debug_trip_irq_en;
   logic overrun_irq_en;
   logic cycle_boundary_irq_en;
   logic restart_irq_en;
   logic wrap_irq_en;

   assign channel_match_irq_en = enable_q[TCEV_BIT_MATCH_LO +: 4];
   assign nonrecov_trip_irq_en = enable_q[TCEV_BIT_NONREC_LO +: 2];
   assign recoverable_b_irq_en = enable_q[TCEV_BIT_RECOV_B];
   assign recoverable_a_irq_en = enable_q[TCEV_BIT_RECOV_A];
   assign halted_debug_trip_irq_en = enable_q[TCEV_BIT_HALT_TRIP];
   assign overrun_irq_en = enable_q[TCEV_BIT_OVERRUN];
   assign cycle_boundary_irq_en = enable_q[TCEV_BIT_CYCLE];
   assign restart_irq_en = enable_q[TCEV_BIT_RESTART];
   assign wrap_irq_en = enable_q[TCEV_BIT_WRAP];

   ////////////////////////////////////////////////////////////////////////
   // Interrupt request
   // Registered so the line is glitch free; costs one cycle of latency.

   logic [TCEV_DW-1:0] gated_flags;
   logic any_pending;

   assign gated_flags = {
      12'h000,
      irq_flags[TCEV_BIT_MATCH_LO +: 4] & channel_match_irq_en,
      irq_flags[TCEV_BIT_NONREC_LO +: 2] & nonrecov_trip_irq_en,
      irq_flags[TCEV_BIT_RECOV_B] & recoverable_b_irq_en,
      irq_flags[TCEV_BIT_RECOV_A] & recoverable_a_irq_en,
      irq_flags[TCEV_BIT_HALT_TRIP] & halted_debug_trip_irq_en,
      7'h00,
      irq_flags[TCEV_BIT_OVERRUN] & overrun_irq_en,
      irq_flags[TCEV_BIT_CYCLE] & cycle_boundary_irq_en,
      irq_flags[TCEV_BIT_RESTART] & restart_irq_en,
      irq_flags[TCEV_BIT_WRAP] & wrap_irq_en
   };

   assign any_pending = |gated_flags; // R24

   logic timer_irq_q;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         timer_irq_q <= 1'b0;
      end else begin
         timer_irq_q <= any_pending; // R24
      end
   end

   assign timer_irq = timer_irq_q;

   ////////////////////////////////////////////////////////////////////////
   // Event decoding

   tcev_act_if act ();

   tcev_decode u_decode (
      .sys_clk(sys_clk),
      .rst(rst),
      .input0_action_sel(input0_action_sel_q),
      .input1_action_sel(input1_action_sel_q),
      .timer_event_in0(timer_event_in0),
      .timer_event_in1(timer_event_in1),
      .counter_running(counter_running),
      .act(act.drv)
   );

   assign ctr_start = act.start;
   assign ctr_retrigger = act.retrigger;
   assign ctr_tally = act.tally;
   assign ctr_step_up = act.step_up;
   assign ctr_level_count = act.level_count;
   assign ctr_dir_down = act.dir_down;
   assign ctr_stop = act.stop;
   assign ctr_step_down = act.step_down;
   assign capture_period_width = act.cap_period_width;
   assign capture_width_period = act.cap_width_period;
   assign fault_trip0 = act.fault0;
   assign fault_trip1 = act.fault1;

   ////////////////////////////////////////////////////////////////////////
   // Sticky trip status
   // Lets software see a fault request even after the pulse has gone.

   logic [1:0] trip_seen_q;
   logic [1:0] trip_seen_d;
   logic [1:0] trip_hit;

   assign trip_hit = {act.fault1, act.fault0};

   always_comb begin
      trip_seen_d = trip_seen_q;
      if (wr_trip_stat) begin
         trip_seen_d = trip_seen_q & ~reg_wdata[1:0];
      end
      // New trip wins over a clear in the same cycle
      trip_seen_d = trip_seen_d | trip_hit;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         trip_seen_q <= TCEV_RST_TRIP;
      end else begin
         trip_seen_q <= trip_seen_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read back
   // Both enable views return the same mask; unmapped reads give zero.

   logic [TCEV_DW-1:0] rdata_d;
   logic [TCEV_DW-1:0] rdata_q;

   always_comb begin
      rdata_d = '0;
      if (reg_rd) begin
         if (hit_event_ctrl) begin
            rdata_d = {26'h0000000, input1_action_sel_q,
                       input0_action_sel_q};
         end else if (hit_enable_clr || hit_enable_set) begin
            rdata_d = enable_q & TCEV_ENABLE_IMPL; // R08 R09 R20 R25
         end else if (hit_trip_stat) begin
            rdata_d = {30'h00000000, trip_seen_q};
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

endmodule : tcev_top

// ### tb/tcev_top_asserts.sv
/*
 * Checker for tcev_top: event decode timing, shared enable mask views
 * and the masked interrupt request.
 * Assumes it is bound to tcev_top and sees only its ports.
 */
`timescale 1ns/100ps
module tcev_top_asserts (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [tcev_pkg::TCEV_AW-1:0] reg_addr,
   input wire logic [tcev_pkg::TCEV_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [tcev_pkg::TCEV_DW-1:0] reg_rdata,
   input wire logic timer_event_in0,
   input wire logic timer_event_in1,
   input wire logic counter_running,
   input wire logic [tcev_pkg::TCEV_DW-1:0] irq_flags,
   input wire logic [tcev_pkg::TCEV_DW-1:0] irq_enable,
   input wire logic timer_irq,
   input wire logic ctr_start,
   input wire logic ctr_retrigger,
   input wire logic ctr_tally,
   input wire logic ctr_step_up,
   input wire logic ctr_level_count,
   input wire logic ctr_dir_down,
   input wire logic ctr_stop,
   input wire logic ctr_step_down,
   input wire logic capture_period_width,
   input wire logic capture_width_period,
   input wire logic fault_trip0,
   input wire logic fault_trip1
);
   import tcev_pkg::*;
   logic [5:0] sel_q;
   logic [2:0] s0;
   logic [2:0] s1;
   logic wr_set;
   logic wr_clr;

   ////////////////////////////////////////////////////////////////////////
   // Shadow of the selector register, seen only through bus writes
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sel_q <= 6'h00;
      end else if (reg_wr && reg_addr == TCEV_OFS_EVENT_CTRL) begin
         sel_q <= reg_wdata[5:0];
      end
   end
   assign s0 = sel_q[2:0];
   assign s1 = sel_q[5:3];
   assign wr_set = reg_wr && reg_addr == TCEV_OFS_ENABLE_SET;
   assign wr_clr = reg_wr && reg_addr == TCEV_OFS_ENABLE_CLR;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   a_retrig_start: assert property (
      timer_event_in0 && s0 == TCEV_ACT_RETRIGGER |=>
      ctr_start != $past(counter_running) &&
      ctr_retrigger == $past(counter_running))
      else $error("retrigger decode wrong");
   a_level_count: assert property (
      ctr_level_count == $past(timer_event_in0 && s0 == TCEV_ACT0_LEVEL_COUNT))
      else $error("level count wrong");
   a_step_up: assert property (
      ctr_step_up == $past(timer_event_in0 && s0 == TCEV_ACT0_STEP_UP))
      else $error("step up wrong");
   a_reserved_quiet: assert property (
      timer_event_in0 && s0 == TCEV_ACT0_RESERVED |=> !(ctr_tally ||
      ctr_step_up || ctr_level_count || fault_trip0) && ctr_start ==
      $past(timer_event_in1 && s1 == TCEV_ACT_RETRIGGER && !counter_running))
      else $error("reserved code acted");
   a_dir_level: assert property (
      ctr_dir_down == $past(timer_event_in1 && s1 == TCEV_ACT1_DIRECTION))
      else $error("direction level wrong");
   a_cap_pw: assert property (
      timer_event_in1 && s1 == TCEV_ACT1_PERIOD_WIDTH |=>
      capture_period_width && !capture_width_period)
      else $error("period width capture wrong");
   a_cap_wp: assert property (
      timer_event_in1 && s1 == TCEV_ACT1_WIDTH_PERIOD |=>
      capture_width_period && !capture_period_width)
      else $error("width period capture wrong");
   a_set_write: assert property (
      wr_set |=> irq_enable ==
      ($past(irq_enable) | ($past(reg_wdata) & TCEV_ENABLE_IMPL)))
      else $error("set write wrong");
   a_clr_write: assert property (
      wr_clr |=> irq_enable == ($past(irq_enable) & ~$past(reg_wdata)))
      else $error("clear write wrong");
   a_read_view: assert property (
      reg_rd && (reg_addr == TCEV_OFS_ENABLE_CLR ||
      reg_addr == TCEV_OFS_ENABLE_SET) |=> reg_rdata == $past(irq_enable))
      else $error("enable read wrong");
   a_irq_level: assert property (
      timer_irq == |$past(irq_flags & irq_enable))
      else $error("interrupt request wrong");
   a_unimpl_zero: assert property (
      (irq_enable & ~TCEV_ENABLE_IMPL) == 32'h0000_0000)
      else $error("unimplemented enable set");
endmodule : tcev_top_asserts

bind tcev_top tcev_top_asserts u_chk (.sys_clk, .rst, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .timer_event_in0,
   .timer_event_in1, .counter_running, .irq_flags, .irq_enable,
   .timer_irq, .ctr_start, .ctr_retrigger, .ctr_tally, .ctr_step_up,
   .ctr_level_count, .ctr_dir_down, .ctr_stop, .ctr_step_down,
   .capture_period_width, .capture_width_period, .fault_trip0,
   .fault_trip1);

// ### tb/tcev_top_tb.sv
/*
 * Self-checking bench for tcev_top: reset values, enable views,
 * interrupt masking and every action code on both event inputs.
 * Assumes the one-cycle register port and registered decode outputs.
 */
`timescale 1ns/100ps
module tcev_top_tb;
   import tcev_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [TCEV_AW-1:0] reg_addr = 8'h00;
   logic [TCEV_DW-1:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic timer_event_in0 = 1'b0;
   logic timer_event_in1 = 1'b0;
   logic counter_running = 1'b0;
   logic [TCEV_DW-1:0] irq_flags = 32'h0;
   logic [TCEV_DW-1:0] reg_rdata, irq_enable;
   logic timer_irq, ctr_start, ctr_retrigger, ctr_tally, ctr_step_up;
   logic ctr_level_count, ctr_dir_down, ctr_stop, ctr_step_down;
   logic capture_period_width, capture_width_period;
   logic fault_trip0, fault_trip1;
   logic [31:0] acts;
   int err_total = 0;
   int checks = 0;
   int cycles = 0;

   tcev_top uut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .timer_event_in0, .timer_event_in1, .counter_running,
      .irq_flags, .irq_enable, .timer_irq, .ctr_start, .ctr_retrigger,
      .ctr_tally, .ctr_step_up, .ctr_level_count, .ctr_dir_down, .ctr_stop,
      .ctr_step_down, .capture_period_width, .capture_width_period,
      .fault_trip0, .fault_trip1);
   assign acts = {20'h0, ctr_start, ctr_retrigger, ctr_tally, ctr_step_up,
      ctr_level_count, ctr_dir_down, ctr_stop, ctr_step_down,
      capture_period_width, capture_width_period, fault_trip0, fault_trip1};

   always #5 sys_clk = ~sys_clk;

   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test

   // Whole run is well under a thousand cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         stop_test();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // Read data stands only in the cycle after the strobe
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk($sformatf("read %h", a), exp, reg_rdata);
   endtask : rdchk

   task automatic do_reset;
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
   endtask : do_reset

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      wr(TCEV_OFS_ENABLE_SET, 32'hffff_ffff);
      wr(TCEV_OFS_EVENT_CTRL, 32'h0000_003f);
      do_reset();
      #1;
      chk("enable", 32'h0, irq_enable);
      rdchk(TCEV_OFS_ENABLE_CLR, 32'h0);
      rdchk(TCEV_OFS_ENABLE_SET, 32'h0);
      rdchk(TCEV_OFS_EVENT_CTRL, 32'h0);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_views;
      logic [31:0] m;
      wr(TCEV_OFS_ENABLE_SET, 32'hffff_ffff);
      rdchk(TCEV_OFS_ENABLE_CLR, 32'h000f_f80f);
      for (int b = 0; b < 32; b++) begin
         if (32'h000f_f80f & (32'h1 << b)) begin
            m = 32'h000f_f80f & ~(32'h1 << b);
            wr(TCEV_OFS_ENABLE_SET, 32'hffff_ffff);
            wr(TCEV_OFS_ENABLE_CLR, 32'h1 << b);
            rdchk(TCEV_OFS_ENABLE_SET, m);
            rdchk(TCEV_OFS_ENABLE_CLR, m);
         end
      end
      wr(TCEV_OFS_ENABLE_SET, 32'h0);
      wr(TCEV_OFS_ENABLE_CLR, 32'h0);
      rdchk(TCEV_OFS_ENABLE_CLR, m);
      rdchk(8'h40, 32'h0);
      $display("t_views done");
   endtask : t_views

   task automatic t_irq;
      wr(TCEV_OFS_ENABLE_CLR, 32'hffff_ffff);
      irq_flags <= 32'h000f_f80f;
      repeat (3) @(posedge sys_clk);
      #1;
      chk("irq masked", 32'h0, timer_irq);
      wr(TCEV_OFS_ENABLE_SET, 32'h0000_0004);
      repeat (2) @(posedge sys_clk);
      #1;
      chk("irq enabled", 32'h1, timer_irq);
      @(posedge sys_clk);
      irq_flags <= 32'h000f_f80b;
      repeat (2) @(posedge sys_clk);
      #1;
      chk("irq flag gone", 32'h0, timer_irq);
      $display("t_irq done");
   endtask : t_irq

   // Bits: start retrig tally up level dir stop down pw wp f0 f1
   function automatic logic [11:0] exp_act(input int ch,
         input logic [2:0] c, input logic run);
      logic [11:0] v;
      v = 12'h000;
      if (c == 3'h1) begin
         v[run ? 10 : 11] = 1'b1;
      end else if (ch == 0) begin
         case (c)
            3'h2: v[9] = 1'b1;
            3'h3: v[11] = 1'b1;
            3'h4: v[8] = 1'b1;
            3'h5: v[7] = 1'b1;
            3'h7: v[1] = 1'b1;
            default: v = 12'h000;
         endcase
      end else if (c != 3'h0) begin
         v[8 - c] = 1'b1;
         if (c == 3'h7) begin
            v = 12'h001;
         end
      end
      return v;
   endfunction : exp_act

   task automatic t_events;
      logic [31:0] e;
      for (int ch = 0; ch < 2; ch++) begin
         for (int r = 0; r < 2; r++) begin
            for (int c = 0; c < 8; c++) begin
               wr(TCEV_OFS_EVENT_CTRL, ch ? c << 3 : c);
               @(posedge sys_clk);
               counter_running <= r[0];
               timer_event_in0 <= (ch == 0);
               timer_event_in1 <= (ch == 1);
               @(posedge sys_clk);
               timer_event_in0 <= 1'b0;
               timer_event_in1 <= 1'b0;
               #1;
               e = {20'h0, exp_act(ch, c[2:0], r[0])};
               chk($sformatf("act %0d %0d %0d", ch, r, c), e,
                  acts);
            end
         end
      end
      $display("t_events done");
   endtask : t_events

   // Both fault codes have fired by now; status is sticky, write 1 clears
   task automatic t_trip;
      rdchk(TCEV_OFS_TRIP_STAT, 32'h3);
      wr(TCEV_OFS_TRIP_STAT, 32'h1);
      rdchk(TCEV_OFS_TRIP_STAT, 32'h2);
      wr(TCEV_OFS_TRIP_STAT, 32'h2);
      rdchk(TCEV_OFS_TRIP_STAT, 32'h0);
      $display("t_trip done");
   endtask : t_trip

   initial begin
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset();
      t_views();
      t_irq();
      t_events();
      t_trip();
      stop_test();
   end
endmodule : tcev_top_tb
